// >>> hdlctx_pkg.sv
// shared constants, register map and types of the hdlc transmit unit
package hdlctx_pkg;
	// ****************************************
	// register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [9:0] IDX_CFG    = 10'h0a8;
	localparam logic [9:0] IDX_START  = 10'h0a9;
	localparam logic [9:0] IDX_LOW    = 10'h0aa;
	localparam logic [9:0] IDX_IEN    = 10'h0ab;
	localparam logic [9:0] IDX_STATUS = 10'h0ac;
	localparam logic [9:0] IDX_DATA   = 10'h0ad;
	// ****************************************
	// field positions
	// ****************************************
	localparam int CFG_EN     = 0;
	localparam int CFG_CRC    = 1;
	localparam int CFG_ABORT  = 2;
	localparam int CFG_EOM    = 3;
	localparam int CFG_REPORT_INSERT_ENABLE   = 5;
	localparam int CFG_QCLR   = 6;
	localparam int CFG_SHARE  = 7;
	localparam int EV_LOW     = 0;
	localparam int EV_UDR     = 1;
	localparam int EV_OVR     = 2;
	localparam int EV_FULL    = 3;
	localparam int EV_RPT     = 4;
	localparam int ST_BELOW   = 5;
	localparam int ST_FULLNOW = 6;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic       RST_SHARE = 1'b1;
	localparam logic       RST_CRC   = 1'b0;
	localparam logic [6:0] RST_START = 7'h40;
	localparam logic [6:0] RST_LOW   = 7'h04;
	// ****************************************
	// queue and line patterns
	// ****************************************
	localparam int          Q_DEPTH   = 128;
	localparam logic [7:0]  Q_FULLCNT = 8'h80;
	localparam logic [7:0]  PAT_FLAG  = 8'h7e;
	localparam logic [7:0]  PAT_ABORT = 8'hfe;
	localparam logic [7:0]  PAT_ONES  = 8'hff;
	localparam logic [3:0]  BITS_BYTE = 4'h8;
	localparam logic [2:0]  STUFF_RUN = 3'h5;
	localparam logic [15:0] CRC_INIT  = 16'hffff;
	localparam logic [15:0] CRC_POLY  = 16'h1021;
	localparam logic [1:0]  PRE_FLAGS = 2'h2;
	typedef enum logic [5:0] {
		ST_OFF   = 6'h01,
		ST_FLAG  = 6'h02,
		ST_DATA  = 6'h04,
		ST_FCS   = 6'h08,
		ST_ABORT = 6'h10,
		ST_RPT   = 6'h20
	} hdlctx_state_t;
endpackage

// >>> hdlctx_queue.sv
// 128-byte transmit queue with end-of-packet marks
module hdlctx_queue (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       clr,
	input  wire logic       wr,
	input  wire logic [7:0] din,
	input  wire logic       mark,
	input  wire logic       rd,
	output logic      [7:0] dout,
	output logic            dlast,
	output logic      [7:0] count
);
	logic [7:0]   mem [hdlctx_pkg::Q_DEPTH];
	logic [127:0] mark_r;
	logic [6:0]   wp_r;
	logic [6:0]   rp_r;

	assign dout  = mem[rp_r];
	assign dlast = mark_r[rp_r];

	always_ff @(posedge pclk) begin
		if (wr) begin
			mem[wp_r] <= din;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_r  <= 7'h00;
			rp_r  <= 7'h00;
			count <= 8'h00;
		end else if (clr) begin
			wp_r  <= 7'h00;
			rp_r  <= 7'h00;
			count <= 8'h00;
		end else begin
			if (wr) begin
				wp_r <= wp_r + 7'h01;
			end
			if (rd) begin
				rp_r <= rp_r + 7'h01;
			end
			count <= count + {7'h00, wr} - {7'h00, rd};
		end
	end

	// a late end mark tags the byte written most recently, if still queued
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mark_r <= '0;
		end else begin
			if (mark && count != 8'h00) begin
				mark_r[wp_r - 7'h01] <= 1'b1;
			end
			if (wr) begin
				mark_r[wp_r] <= 1'b0;
			end
		end
	end
endmodule

// >>> hdlctx_framer.sv
// hdlc transmit framer: apb registers, queue control, bit serializer
// Functional notes
// - abort: finish byte, send abort, clear queue
// - held abort repeats; rising edge forces one
// - report beats abort; two flags before it
// - end mark closes packet, check word appended
// - data write clears end mark
// - report inserted after current packet and flags
// - report enable works in first instance only
// - queue clear acts within one cycle
// - shared flag mode: one flag between frames
// - start sending when fill exceeds start level
// - stop at packet end, fill not above start
// - below low level sets latched and live bits
// - enabled latched flags pull irq low
// - status read clears latched flags
// - status write clears underrun
// - queue empty mid packet sets underrun
// - write into full queue sets overrun
// - full at 128 bytes, latched on entry
// - waiting report sets report ready flag
// - bytes go out bit 0 first
// - enabled sends flags; disabled sends ones
// - crc16 ccitt, high bit first, on queued packets and reports
module hdlctx_framer #(
	parameter int INSTANCE = 1
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        bit_slot,
	output logic             dl_bit,
	input  wire logic        rpt_pending,
	input  wire logic [7:0]  rpt_byte,
	input  wire logic        rpt_last,
	output logic             rpt_take,
	output logic             irq_n
);
	// ****************************************
	// declarations
	// ****************************************
	logic        en_r, crc_on_r, abt_r, eom_r, report_insert_enable_r, qclr_r, share_r;
	logic [6:0]  start_r, low_r;
	logic [4:0]  ien_r, ev_r, ev_set, ev_clr;
	logic [7:0]  txb_r, q_dout, q_cnt;
	logic        q_last, q_empty, q_full, q_wr, q_rd, q_clr;
	logic        setup, wr_acc, rd_acc;
	logic        sel_cfg, sel_start, sel_low, sel_ien, sel_stat, sel_data;
	logic        below, below_q, full_q, rptp_q;
	logic [31:0] rdat;
	logic        started_r;
	hdlctx_pkg::hdlctx_state_t st_r, nst;
	logic [7:0]  sh_r, lv;
	logic [3:0]  bcnt_r;
	logic [2:0]  ones_r;
	logic [15:0] crc_r;
	logic        stuff_r, crc_act_r, last_r, fcs2_r, owe_r, abt_q;
	logic [1:0]  flg_r, flg_n, need;
	logic        ld, lstuff, lcrc, crc_clr, take, udr_evt, owe_clr;
	logic        last_n, fcs2_n, report_insert_enable_eff, rpt_go, gap_ok, abt_go, bit_out;

	function automatic logic [7:0] rev8(input logic [7:0] x);
		logic [7:0] y;
		y = 8'h00;
		for (int i = 0; i < 8; i++) begin
			y[i] = x[7 - i];
		end
		return y;
	endfunction

	// ****************************************
	// apb decode
	// ****************************************
	assign setup    = psel & ~penable;
	assign wr_acc   = psel & penable & pready & pwrite;
	assign rd_acc   = psel & penable & pready & ~pwrite;

	always_comb begin
		sel_cfg   = 1'b0;
		sel_start = 1'b0;
		sel_low   = 1'b0;
		sel_ien   = 1'b0;
		sel_stat  = 1'b0;
		sel_data  = 1'b0;
		if (paddr[11:2] == hdlctx_pkg::IDX_CFG) begin
			sel_cfg = 1'b1;
		end else if (paddr[11:2] == hdlctx_pkg::IDX_START) begin
			sel_start = 1'b1;
		end else if (paddr[11:2] == hdlctx_pkg::IDX_LOW) begin
			sel_low = 1'b1;
		end else if (paddr[11:2] == hdlctx_pkg::IDX_IEN) begin
			sel_ien = 1'b1;
		end else if (paddr[11:2] == hdlctx_pkg::IDX_STATUS) begin
			sel_stat = 1'b1;
		end else if (paddr[11:2] == hdlctx_pkg::IDX_DATA) begin
			sel_data = 1'b1;
		end
	end

	always_comb begin
		rdat = 32'h0000_0000;
		if (sel_cfg) begin
			rdat[7:0] = {share_r, qclr_r, report_insert_enable_r, 1'b0, eom_r, abt_r, crc_on_r, en_r};
		end else if (sel_start) begin
			rdat[6:0] = start_r;
		end else if (sel_low) begin
			rdat[6:0] = low_r;
		end else if (sel_ien) begin
			rdat[4:0] = ien_r;
		end else if (sel_stat) begin
			rdat[6:0] = {q_full, below, ev_r};
		end else if (sel_data) begin
			rdat[7:0] = txb_r;
		end
	end

	// zero-wait slave: data sampled in setup, ready in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata  <= rdat;
				pslverr <= ~(sel_cfg | sel_start | sel_low | sel_ien | sel_stat | sel_data);
			end
		end
	end

	// ****************************************
	// register file
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r     <= 1'b0;
			crc_on_r <= hdlctx_pkg::RST_CRC;
			abt_r    <= 1'b0;
			report_insert_enable_r   <= 1'b0;
			qclr_r   <= 1'b0;
			share_r  <= hdlctx_pkg::RST_SHARE;
		end else if (wr_acc && sel_cfg) begin
			en_r     <= pwdata[hdlctx_pkg::CFG_EN];
			crc_on_r <= pwdata[hdlctx_pkg::CFG_CRC];
			abt_r    <= pwdata[hdlctx_pkg::CFG_ABORT];
			report_insert_enable_r   <= pwdata[hdlctx_pkg::CFG_REPORT_INSERT_ENABLE];
			qclr_r   <= pwdata[hdlctx_pkg::CFG_QCLR];
			share_r  <= pwdata[hdlctx_pkg::CFG_SHARE];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eom_r <= 1'b0;
		end else if (wr_acc && sel_data) begin
			eom_r <= 1'b0;
		end else if (wr_acc && sel_cfg) begin
			eom_r <= pwdata[hdlctx_pkg::CFG_EOM];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_r <= hdlctx_pkg::RST_START;
			low_r   <= hdlctx_pkg::RST_LOW;
			ien_r   <= 5'h00;
			txb_r   <= 8'h00;
		end else if (wr_acc) begin
			if (sel_start) begin
				start_r <= pwdata[6:0];
			end
			if (sel_low) begin
				low_r <= pwdata[6:0];
			end
			if (sel_ien) begin
				ien_r <= pwdata[4:0];
			end
			if (sel_data) begin
				txb_r <= pwdata[7:0];
			end
		end
	end

	// ****************************************
	// queue
	// ****************************************
	assign q_empty = (q_cnt == 8'h00);
	assign q_full  = (q_cnt == hdlctx_pkg::Q_FULLCNT);
	assign q_wr    = wr_acc & sel_data & ~q_full;
	// abort keeps the queue flushed; the byte on the line is already out of it
	assign q_clr   = qclr_r | abt_r;
	assign below   = q_empty | (q_cnt < {1'b0, low_r});

	hdlctx_queue u_queue (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (q_clr),
		.wr      (q_wr),
		.din     (pwdata[7:0]),
		.mark    (wr_acc & sel_cfg & pwdata[hdlctx_pkg::CFG_EOM]),
		.rd      (q_rd),
		.dout    (q_dout),
		.dlast   (q_last),
		.count   (q_cnt)
	);

	// ****************************************
	// events and interrupt
	// ****************************************
	assign ev_set[hdlctx_pkg::EV_LOW]  = below & ~below_q;
	assign ev_set[hdlctx_pkg::EV_UDR]  = udr_evt;
	assign ev_set[hdlctx_pkg::EV_OVR]  = wr_acc & sel_data & q_full;
	assign ev_set[hdlctx_pkg::EV_FULL] = q_full & ~full_q;
	assign ev_set[hdlctx_pkg::EV_RPT]  = rpt_pending & ~rptp_q;

	// only bits shown to the reader are cleared; set beats clear
	always_comb begin
		ev_clr = 5'h00;
		if (rd_acc && sel_stat) begin
			ev_clr = prdata[4:0];
		end
		if (wr_acc && sel_stat) begin
			ev_clr[hdlctx_pkg::EV_UDR] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_r    <= 5'h00;
			below_q <= 1'b0;
			full_q  <= 1'b0;
			rptp_q  <= 1'b0;
			irq_n   <= 1'b1;
		end else begin
			ev_r    <= (ev_r & ~ev_clr) | ev_set;
			below_q <= below;
			full_q  <= q_full;
			rptp_q  <= rpt_pending;
			irq_n   <= ~|(ev_r & ien_r);
		end
	end

	// ****************************************
	// start and stop of queue draining
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			started_r <= 1'b0;
		end else if (q_cnt > {1'b0, start_r}) begin
			started_r <= 1'b1;
		end else if (st_r != hdlctx_pkg::ST_DATA && st_r != hdlctx_pkg::ST_FCS) begin
			started_r <= 1'b0;
		end
	end

	// ****************************************
	// unit selection at byte boundaries
	// ****************************************
	assign report_insert_enable_eff = report_insert_enable_r & (INSTANCE == 1);
	assign rpt_go   = rpt_pending & report_insert_enable_eff;
	assign need     = share_r ? 2'h1 : 2'h2;
	assign gap_ok   = flg_r >= need;
	assign abt_go   = (abt_r | owe_r) & (st_r != hdlctx_pkg::ST_FLAG | gap_ok);
	// an owed stuffed zero goes out before the next unit is loaded
	assign ld       = (bcnt_r == 4'h0) & ~(stuff_r & (ones_r == hdlctx_pkg::STUFF_RUN));

	always_comb begin
		nst     = st_r;
		lv      = hdlctx_pkg::PAT_FLAG;
		lstuff  = 1'b0;
		lcrc    = 1'b0;
		crc_clr = 1'b0;
		q_rd    = 1'b0;
		take    = 1'b0;
		udr_evt = 1'b0;
		owe_clr = 1'b0;
		flg_n   = flg_r;
		last_n  = last_r;
		fcs2_n  = fcs2_r;
		if (!ld) begin
			nst = st_r;
		end else if (!en_r) begin
			nst   = hdlctx_pkg::ST_OFF;
			lv    = hdlctx_pkg::PAT_ONES;
			flg_n = 2'h0;
		end else begin
			case (st_r)
				hdlctx_pkg::ST_DATA, hdlctx_pkg::ST_RPT: begin
					if (st_r == hdlctx_pkg::ST_DATA && abt_r) begin
						nst     = hdlctx_pkg::ST_ABORT;
						lv      = hdlctx_pkg::PAT_ABORT;
						owe_clr = 1'b1;
						flg_n   = 2'h0;
					end else if (last_r && crc_on_r) begin
						nst    = hdlctx_pkg::ST_FCS;
						lv     = rev8(~crc_r[15:8]);
						lstuff = 1'b1;
						fcs2_n = 1'b1;
					end else if (last_r) begin
						nst   = hdlctx_pkg::ST_FLAG;
						flg_n = 2'h1;
					end else if (st_r == hdlctx_pkg::ST_RPT) begin
						lv     = rpt_byte;
						take   = 1'b1;
						lstuff = 1'b1;
						lcrc   = 1'b1;
						last_n = rpt_last;
					end else if (q_empty) begin
						nst     = hdlctx_pkg::ST_ABORT;
						lv      = hdlctx_pkg::PAT_ABORT;
						udr_evt = 1'b1;
						flg_n   = 2'h0;
					end else begin
						lv     = q_dout;
						q_rd   = 1'b1;
						lstuff = 1'b1;
						lcrc   = 1'b1;
						last_n = q_last;
					end
				end
				hdlctx_pkg::ST_FCS: begin
					if (fcs2_r) begin
						lv     = rev8(~crc_r[7:0]);
						lstuff = 1'b1;
						fcs2_n = 1'b0;
					end else begin
						nst   = hdlctx_pkg::ST_FLAG;
						flg_n = 2'h1;
					end
				end
				default: begin
					if (rpt_go && flg_r >= hdlctx_pkg::PRE_FLAGS) begin
						nst     = hdlctx_pkg::ST_RPT;
						lv      = rpt_byte;
						take    = 1'b1;
						lstuff  = 1'b1;
						lcrc    = 1'b1;
						crc_clr = 1'b1;
						last_n  = rpt_last;
						flg_n   = 2'h0;
					end else if (!rpt_go && abt_go) begin
						nst     = hdlctx_pkg::ST_ABORT;
						lv      = hdlctx_pkg::PAT_ABORT;
						owe_clr = 1'b1;
						flg_n   = 2'h0;
					end else if (!rpt_go && started_r && !q_empty && gap_ok) begin
						nst     = hdlctx_pkg::ST_DATA;
						lv      = q_dout;
						q_rd    = 1'b1;
						lstuff  = 1'b1;
						lcrc    = 1'b1;
						crc_clr = 1'b1;
						last_n  = q_last;
						flg_n   = 2'h0;
					end else begin
						nst   = hdlctx_pkg::ST_FLAG;
						flg_n = (flg_r == 2'h3) ? flg_r : flg_r + 2'h1;
					end
				end
			endcase
		end
	end

	// ****************************************
	// serializer
	// ****************************************
	// bit_slot must not come in the cycle right after a unit's last bit
	assign bit_out = sh_r[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r      <= hdlctx_pkg::ST_OFF;
			sh_r      <= hdlctx_pkg::PAT_ONES;
			bcnt_r    <= 4'h0;
			ones_r    <= 3'h0;
			crc_r     <= hdlctx_pkg::CRC_INIT;
			stuff_r   <= 1'b0;
			crc_act_r <= 1'b0;
			last_r    <= 1'b0;
			fcs2_r    <= 1'b0;
			flg_r     <= 2'h0;
			dl_bit    <= 1'b1;
			rpt_take  <= 1'b0;
		end else begin
			rpt_take <= take;
			if (ld) begin
				st_r      <= nst;
				sh_r      <= lv;
				bcnt_r    <= hdlctx_pkg::BITS_BYTE;
				stuff_r   <= lstuff;
				crc_act_r <= lcrc;
				last_r    <= last_n;
				fcs2_r    <= fcs2_n;
				flg_r     <= flg_n;
				if (!lstuff) begin
					ones_r <= 3'h0;
				end
				if (crc_clr) begin
					crc_r <= hdlctx_pkg::CRC_INIT;
				end
			end else if (bit_slot) begin
				if (stuff_r && ones_r == hdlctx_pkg::STUFF_RUN) begin
					dl_bit <= 1'b0;
					ones_r <= 3'h0;
				end else begin
					dl_bit <= bit_out;
					sh_r   <= {1'b1, sh_r[7:1]};
					bcnt_r <= bcnt_r - 4'h1;
					ones_r <= bit_out ? ones_r + {2'h0, ones_r != 3'h7} : 3'h0;
					if (crc_act_r) begin
						crc_r <= {crc_r[14:0], 1'b0} ^
							((crc_r[15] ^ bit_out) ? hdlctx_pkg::CRC_POLY : 16'h0000);
					end
				end
			end
		end
	end

	// rising edge of abort request owes at least one pattern
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			owe_r <= 1'b0;
			abt_q <= 1'b0;
		end else begin
			abt_q <= abt_r;
			if (abt_r && !abt_q) begin
				owe_r <= 1'b1;
			end else if (owe_clr) begin
				owe_r <= 1'b0;
			end
		end
	end
endmodule

// >>> hdlctx_framer_properties.sv
// port checker of the hdlc transmit framer
module hdlctx_framer_properties (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        bit_slot,
	input wire logic        dl_bit,
	input wire logic        rpt_pending,
	input wire logic [7:0]  rpt_byte,
	input wire logic        rpt_last,
	input wire logic        rpt_take,
	input wire logic        irq_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// shadows of the written registers
	// ****************************************
	logic       wr_ok;
	logic       rd_ok;
	logic       en_seen_r;
	logic       report_insert_enable_r;
	logic [4:0] ien_r;
	assign wr_ok = psel && penable && pready && pwrite;
	assign rd_ok = psel && penable && pready && !pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_seen_r <= 1'b0;
			report_insert_enable_r    <= 1'b0;
		end else if (wr_ok && paddr[11:2] == hdlctx_pkg::IDX_CFG) begin
			en_seen_r <= en_seen_r | pwdata[hdlctx_pkg::CFG_EN];
			report_insert_enable_r    <= pwdata[hdlctx_pkg::CFG_REPORT_INSERT_ENABLE];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ien_r <= 5'h00;
		end else if (wr_ok && paddr[11:2] == hdlctx_pkg::IDX_IEN) begin
			ien_r <= pwdata[4:0];
		end
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_idle_ones: assert property (!en_seen_r |-> dl_bit)
		else $error("line bit low before the unit was enabled");
	a_bit_on_slot: assert property ($changed(dl_bit) |-> $past(bit_slot))
		else $error("line bit moved without a slot");
	a_irq_needs_enable: assert property (!irq_n |-> $past(ien_r) != 5'h00)
		else $error("irq low with all enables off");
	a_ien_readback: assert property (rd_ok && paddr[11:2] == hdlctx_pkg::IDX_IEN
		|-> prdata[4:0] == ien_r) else $error("enable register read back wrong");
	a_take_single: assert property (rpt_take |=> !rpt_take [*8])
		else $error("report bytes taken too close together");
	a_take_pending: assert property (rpt_take |-> $past(rpt_pending))
		else $error("report byte taken with nothing pending");
	a_take_enable: assert property (rpt_take |-> report_insert_enable_r)
		else $error("report byte taken while insertion disabled");
	a_full_low: assert property (rd_ok && paddr[11:2] == hdlctx_pkg::IDX_STATUS
		|-> !(prdata[6] && prdata[5])) else $error("full and below-low both live");
endmodule
bind hdlctx_framer hdlctx_framer_properties i_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .bit_slot(bit_slot),
	.dl_bit(dl_bit), .rpt_pending(rpt_pending), .rpt_byte(rpt_byte),
	.rpt_last(rpt_last), .rpt_take(rpt_take), .irq_n(irq_n));

// >>> hdlctx_line_model.sv
// line slot source, line recorder and two-byte report source
module hdlctx_line_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        slow,
	input  wire logic        rpt_go,
	input  wire logic        dl_bit,
	input  wire logic        rpt_take,
	output logic             bit_slot,
	output logic             rpt_pending,
	output logic      [7:0]  rpt_byte,
	output logic             rpt_last,
	output logic      [63:0] hist
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] gap_r;
	logic       idx_r;
	// slots stay well apart so no slot lands in a reload cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_r    <= 4'h0;
			bit_slot <= 1'b0;
		end else begin
			bit_slot <= gap_r == 4'h0;
			gap_r    <= (gap_r != 4'h0) ? gap_r - 4'h1 : (slow ? 4'h7 : 4'h3);
		end
	end
	// sampled at the next slot, where the previous bit still stands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist <= 64'h0;
		end else if (bit_slot) begin
			hist <= {dl_bit, hist[63:1]};
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rpt_pending <= 1'b0;
			idx_r       <= 1'b0;
		end else if (rpt_go) begin
			rpt_pending <= 1'b1;
			idx_r       <= 1'b0;
		end else if (rpt_take) begin
			rpt_pending <= !idx_r;
			idx_r       <= 1'b1;
		end
	end
	// nothing pending: inverse of the final byte, never a stale copy
	assign rpt_byte = !rpt_pending ? 8'hcb : (idx_r ? 8'h34 : 8'h12);
	assign rpt_last = rpt_pending && idx_r;
endmodule

// >>> hdlctx_framer_test.sv
// register-level test of the hdlc transmit framer
module hdlctx_framer_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        bit_slot, dl_bit, rpt_pending, rpt_last, rpt_take, irq_n, slow, rpt_go;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  rpt_byte;
	logic [63:0] hist, e;
	logic [15:0] crc;
	logic        err;
	int          n_errors, checks_done, e_n, ones;
	hdlctx_framer i_hdlctx_framer (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .bit_slot(bit_slot),
		.dl_bit(dl_bit), .rpt_pending(rpt_pending), .rpt_byte(rpt_byte),
		.rpt_last(rpt_last), .rpt_take(rpt_take), .irq_n(irq_n));
	hdlctx_line_model i_hdlctx_line_model (.pclk(pclk), .presetn(presetn), .slow(slow),
		.rpt_go(rpt_go), .dl_bit(dl_bit), .rpt_take(rpt_take), .bit_slot(bit_slot),
		.rpt_pending(rpt_pending), .rpt_byte(rpt_byte), .rpt_last(rpt_last), .hist(hist));
	always #20 pclk = ~pclk;
	// ****************************************
	// helpers
	// ****************************************
	task automatic end_of_test();
		if (n_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic timeout_hit(input int n);
		if (n >= 4000) begin
			n_errors++;
			end_of_test();
		end
	endtask
	// pacing of 8 cycles after every access still leaves software faster than the line
	task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd);
		int n;
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 4000);
		timeout_hit(n);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] v);
		bus(1'b1, idx, 32'(v));
	endtask
	task automatic rdchk(input logic [9:0] idx, input logic [7:0] m, input logic [7:0] x);
		bus(1'b0, idx, 32'h0000_0000);
		check(32'(rd[7:0] & m), 32'(x));
	endtask
	task automatic put(input logic b, input bit stuff);
		e = {b, e[63:1]};
		e_n++;
		ones = b ? ones + 1 : 0;
		if (stuff && ones == 5) begin
			e = {1'b0, e[63:1]};
			e_n++;
			ones = 0;
		end
	endtask
	task automatic put_byte(input logic [7:0] v, input bit stuff);
		for (int i = 0; i < 8; i++) begin
			crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ v[i]) ? 16'h1021 : 16'h0000);
			put(v[i], stuff);
		end
	endtask
	task automatic start_exp();
		e = 64'h0;
		e_n = 0;
		ones = 0;
		crc = 16'hffff;
	endtask
	task automatic wait_line();
		int n;
		logic [63:0] m;
		m = {64{1'b1}} << (64 - e_n);
		n = 0;
		while (((hist ^ e) & m) !== 64'h0 && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		timeout_hit(n);
		check(32'(((hist ^ e) & m) == 64'h0), 32'h0000_0001);
	endtask
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq_n !== 1'b0 && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		timeout_hit(n);
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0000_0000; slow = 1'b0; rpt_go = 1'b0;
		n_errors = 0;
		checks_done = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(hdlctx_pkg::IDX_CFG, 8'hff, 8'h80);
		rdchk(hdlctx_pkg::IDX_START, 8'h7f, 8'h40);
		rdchk(hdlctx_pkg::IDX_LOW, 8'h7f, 8'h04);
		rdchk(hdlctx_pkg::IDX_IEN, 8'h1f, 8'h00);
		rdchk(hdlctx_pkg::IDX_STATUS, 8'h60, 8'h20);
		bus(1'b0, 10'h3ff, 32'h0000_0000);
		check(32'(err), 32'h0000_0001);
		// one stuffed frame with check word, started by the fill level
		wr(hdlctx_pkg::IDX_LOW, 8'h00);
		wr(hdlctx_pkg::IDX_START, 8'h01);
		wr(hdlctx_pkg::IDX_CFG, 8'h83);
		wr(hdlctx_pkg::IDX_DATA, 8'hff);
		wr(hdlctx_pkg::IDX_DATA, 8'h5a);
		wr(hdlctx_pkg::IDX_CFG, 8'h8b);
		start_exp();
		put_byte(8'h7e, 1'b0);
		crc = 16'hffff;
		ones = 0;
		put_byte(8'hff, 1'b1);
		put_byte(8'h5a, 1'b1);
		for (int i = 15; i >= 0; i--) put(~crc[i], 1'b1);
		put_byte(8'h7e, 1'b0);
		wait_line();
		wr(hdlctx_pkg::IDX_DATA, 8'h11);
		rdchk(hdlctx_pkg::IDX_CFG, 8'hff, 8'h83);
		// fill to the limit while idle, then one byte too many
		wr(hdlctx_pkg::IDX_CFG, 8'h80);
		wr(hdlctx_pkg::IDX_IEN, 8'h04);
		rdchk(hdlctx_pkg::IDX_STATUS, 8'h48, 8'h00);
		for (int i = 0; i < 127; i++) wr(hdlctx_pkg::IDX_DATA, 8'(i));
		rdchk(hdlctx_pkg::IDX_STATUS, 8'h4c, 8'h48);
		wr(hdlctx_pkg::IDX_DATA, 8'haa);
		check(32'(irq_n), 32'h0000_0000);
		rdchk(hdlctx_pkg::IDX_STATUS, 8'h4c, 8'h44);
		rdchk(hdlctx_pkg::IDX_STATUS, 8'h4c, 8'h40);
		check(32'(irq_n), 32'h0000_0001);
		wr(hdlctx_pkg::IDX_CFG, 8'h40);
		wr(hdlctx_pkg::IDX_CFG, 8'h00);
		rdchk(hdlctx_pkg::IDX_STATUS, 8'h61, 8'h21);
		// held abort with data queued below the start level
		wr(hdlctx_pkg::IDX_START, 8'h40);
		wr(hdlctx_pkg::IDX_CFG, 8'h81);
		wr(hdlctx_pkg::IDX_DATA, 8'h66);
		wr(hdlctx_pkg::IDX_CFG, 8'h85);
		start_exp();
		put_byte(8'hfe, 1'b0);
		put_byte(8'hfe, 1'b0);
		wait_line();
		rdchk(hdlctx_pkg::IDX_STATUS, 8'h60, 8'h20);
		wr(hdlctx_pkg::IDX_CFG, 8'h81);
		// packet left open runs dry
		wr(hdlctx_pkg::IDX_START, 8'h00);
		wr(hdlctx_pkg::IDX_LOW, 8'h00);
		wr(hdlctx_pkg::IDX_IEN, 8'h02);
		wr(hdlctx_pkg::IDX_DATA, 8'h55);
		wait_irq();
		check(32'(irq_n), 32'h0000_0000);
		wr(hdlctx_pkg::IDX_STATUS, 8'h00);
		check(32'(irq_n), 32'h0000_0001);
		rdchk(hdlctx_pkg::IDX_STATUS, 8'h02, 8'h00);
		// report insertion on a slow line
		wr(hdlctx_pkg::IDX_CFG, 8'ha1);
		wr(hdlctx_pkg::IDX_IEN, 8'h10);
		slow   <= 1'b1;
		rpt_go <= 1'b1;
		@(posedge pclk);
		rpt_go <= 1'b0;
		wait_irq();
		check(32'(irq_n), 32'h0000_0000);
		start_exp();
		put_byte(8'h7e, 1'b0);
		put_byte(8'h7e, 1'b0);
		put_byte(8'h12, 1'b1);
		put_byte(8'h34, 1'b1);
		put_byte(8'h7e, 1'b0);
		wait_line();
		rdchk(hdlctx_pkg::IDX_STATUS, 8'h10, 8'h10);
		end_of_test();
	end
endmodule
